// File: src/hsp_pkg.sv
// shared constants for the host indirect shared ram port
package hsp_pkg;
  localparam int RAM_AW = 10;
  localparam int RAM_DW = 8;
  localparam int RAM_DEPTH = 1024;
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;
  localparam int RESULT_BYTES = 4;
  //////////////////////////////////////////////////////////////////////////
  // data path region offsets
  localparam logic [7:0] OFF_ADDR_LO = 8'h00;
  localparam logic [7:0] OFF_ADDR_HI = 8'h01;
  localparam logic [7:0] OFF_DATA = 8'h02;
  localparam logic [7:0] OFF_UNUSED = 8'h03;
  localparam logic [7:0] OFF_PROC_RST = 8'h04;
  localparam logic [7:0] OFF_BOOT_MODE = 8'h05;
  // bridge region offset and fields, then the boot mode bit
  localparam logic [7:0] OFF_INT_CSR = 8'h4c;
  localparam int INT_EN_BIT = 0;
  localparam int INT_POL_BIT = 1;
  localparam int INT_ACT_BIT = 2;
  localparam int BUS_INT_EN_BIT = 6;
  localparam int MODE_BIT = 0;
  //////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic INT_EN_RST = 1'b1;
  localparam logic INT_POL_RST = 1'b0;
  localparam logic BUS_INT_EN_RST = 1'b0;
  localparam logic MODE_RST = 1'b0;
  localparam logic [9:0] PTR_RST = 10'h000;
  // mailbox locations
  localparam logic [9:0] MBOX_HOST = 10'h3ff;
  localparam logic [9:0] MBOX_MCU = 10'h3fe;
  //////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROC_RST_NS = 1000;
  localparam logic [5:0] PROC_RST_CYC =
    6'((PROC_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  //////////////////////////////////////////////////////////////////////////
  // controller register offsets, status bits, commands
  localparam logic [7:0] HREG_ADDR = 8'h00;
  localparam logic [7:0] HREG_WDATA = 8'h04;
  localparam logic [7:0] HREG_CMD = 8'h08;
  localparam logic [7:0] HREG_RDATA = 8'h0c;
  localparam logic [7:0] HREG_STAT = 8'h10;
  localparam logic [7:0] HREG_MASK = 8'h14;
  localparam int ST_DONE = 0;
  localparam int ST_DEV = 1;
  localparam int ST_BUSY = 2;
  localparam logic [2:0] CMD_WR_BYTE = 3'h1;
  localparam logic [2:0] CMD_RD_WORD = 3'h2;
  localparam logic [2:0] CMD_PROC_RST = 3'h3;
  localparam logic [2:0] CMD_SET_MODE = 3'h4;
  localparam logic [2:0] CMD_BR_WR = 3'h5;
  localparam logic [2:0] CMD_BR_RD = 3'h6;
endpackage : hsp_pkg

// File: src/hsp_bus_if.sv
// host bus between the controller and the board port
interface hsp_bus_if;
  import hsp_pkg::*;
  logic sel_bridge;
  logic sel_data;
  logic [BUS_AW-1:0] addr;
  logic wr;
  logic rd;
  logic [BUS_DW-1:0] wdata;
  logic [BUS_DW-1:0] rdata;
  logic irq_line;
  modport dev (
    input sel_bridge, sel_data, addr, wr, rd, wdata,
    output rdata, irq_line
  );
  modport host (
    output sel_bridge, sel_data, addr, wr, rd, wdata,
    input rdata, irq_line
  );
endinterface : hsp_bus_if

// File: src/hsp_shared_ram.sv
// two-port byte ram shared by microcontroller and host
module hsp_shared_ram
  import hsp_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic [RAM_AW-1:0] a_addr, // mcu address
  input wire logic [RAM_DW-1:0] a_wdata, // mcu write byte
  input wire logic a_we, // mcu write
  output logic [RAM_DW-1:0] a_rdata, // mcu read byte
  input wire logic [RAM_AW-1:0] b_addr, // host address
  input wire logic [RAM_DW-1:0] b_wdata, // host write byte
  input wire logic b_we, // host write
  output logic [RAM_DW-1:0] b_rdata // host read byte
);
  logic [RAM_DW-1:0] mem [RAM_DEPTH];

  // same-address collision: host write lands last and wins
  always_ff @(posedge clk_sys) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
  end

  assign a_rdata = mem[a_addr];
  assign b_rdata = mem[b_addr];
endmodule : hsp_shared_ram

// File: src/hsp_dev_end.sv
// board end: region decode, ram pointer, mailboxes, interrupt, resets
module hsp_dev_end
  import hsp_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // async reset, high
  hsp_bus_if.dev bus, // host side
  input wire logic [RAM_AW-1:0] mcu_addr, // mcu ram address
  input wire logic [RAM_DW-1:0] mcu_wdata, // mcu write byte
  input wire logic mcu_we, // mcu write strobe
  input wire logic mcu_re, // mcu read strobe
  output logic [RAM_DW-1:0] mcu_rdata, // mcu read byte, next cycle
  output logic mcu_rst, // processor reset
  output logic boot_mode, // firmware download mode
  output logic mcu_mbox_flag // host wrote mcu mailbox
);

  function automatic logic hit(input logic sel, input logic [7:0] a,
                               input logic [7:0] off);
    return sel && (a == off);
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////
  // decode

  logic lo_wr;
  logic hi_wr;
  logic data_wr;
  logic data_rd;
  logic unused_acc;
  logic rst_acc;
  logic mode_wr;
  logic csr_wr;
  logic csr_rd;

  assign lo_wr = bus.wr && hit(bus.sel_data, bus.addr, OFF_ADDR_LO);
  assign hi_wr = bus.wr && hit(bus.sel_data, bus.addr, OFF_ADDR_HI);
  assign data_wr = bus.wr && hit(bus.sel_data, bus.addr, OFF_DATA);
  assign data_rd = bus.rd && hit(bus.sel_data, bus.addr, OFF_DATA);
  // no storage behind it; reads fall to the zero default
  assign unused_acc = (bus.wr || bus.rd)
    && hit(bus.sel_data, bus.addr, OFF_UNUSED);
  assign rst_acc = (bus.wr || bus.rd)
    && hit(bus.sel_data, bus.addr, OFF_PROC_RST);
  assign mode_wr = bus.wr && hit(bus.sel_data, bus.addr, OFF_BOOT_MODE);
  // bridge region: only the interrupt word is mapped
  assign csr_wr = bus.wr && hit(bus.sel_bridge, bus.addr, OFF_INT_CSR);
  assign csr_rd = bus.rd && hit(bus.sel_bridge, bus.addr, OFF_INT_CSR);

  //////////////////////////////////////////////////////////////////////////
  // ram pointer

  logic [RAM_AW-1:0] ptr_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_r <= PTR_RST;
    end else begin
      if (lo_wr) begin
        ptr_r[7:0] <= bus.wdata[7:0];
      end
      if (hi_wr) begin
        ptr_r[9:8] <= bus.wdata[1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shared ram

  logic [RAM_DW-1:0] host_q;
  logic [RAM_DW-1:0] mcu_q;

  // both pointer halves form the location of every data access
  hsp_shared_ram u_ram (
    .clk_sys(clk_sys),
    .a_addr(mcu_addr),
    .a_wdata(mcu_wdata),
    .a_we(mcu_we),
    .a_rdata(mcu_q),
    .b_addr(ptr_r),
    .b_wdata(bus.wdata[7:0]),
    .b_we(data_wr),
    .b_rdata(host_q)
  );

  logic [RAM_DW-1:0] mcu_rdata_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mcu_rdata_r <= '0;
    end else begin
      mcu_rdata_r <= mcu_q;
    end
  end

  assign mcu_rdata = mcu_rdata_r;

  //////////////////////////////////////////////////////////////////////////
  // mailboxes

  logic host_set;
  logic host_clr;
  logic mcu_set;
  logic mcu_clr;
  logic int_act_r;
  logic mcu_mbox_r;

  // firmware writes its host mailbox once a result is in ram
  assign host_set = mcu_we && (mcu_addr == MBOX_HOST);
  assign host_clr = data_rd && (ptr_r == MBOX_HOST);
  assign mcu_set = data_wr && (ptr_r == MBOX_MCU);
  assign mcu_clr = mcu_re && (mcu_addr == MBOX_MCU);

  // set beats clear so a result posted during the read is kept
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      int_act_r <= 1'b0;
    end else if (host_set) begin
      int_act_r <= 1'b1;
    end else if (host_clr) begin
      int_act_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mcu_mbox_r <= 1'b0;
    end else if (mcu_set) begin
      mcu_mbox_r <= 1'b1;
    end else if (mcu_clr) begin
      mcu_mbox_r <= 1'b0;
    end
  end

  assign mcu_mbox_flag = mcu_mbox_r;

  //////////////////////////////////////////////////////////////////////////
  // interrupt control word

  logic int_en_r;
  logic int_pol_r;
  logic bus_int_en_r;
  logic irq_line_r;
  logic irq_on;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      int_en_r <= INT_EN_RST;
      int_pol_r <= INT_POL_RST;
      bus_int_en_r <= BUS_INT_EN_RST;
    end else if (csr_wr) begin
      int_en_r <= bus.wdata[INT_EN_BIT];
      int_pol_r <= bus.wdata[INT_POL_BIT];
      bus_int_en_r <= bus.wdata[BUS_INT_EN_BIT];
    end
  end

  assign irq_on = int_act_r && int_en_r && bus_int_en_r;

  // idle level is the inverse of the chosen active level
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_line_r <= ~INT_POL_RST;
    end else begin
      irq_line_r <= int_pol_r ? irq_on : ~irq_on;
    end
  end

  assign bus.irq_line = irq_line_r;

  //////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the strobe

  logic [BUS_DW-1:0] rdata_r;
  logic [BUS_DW-1:0] csr_word;

  always_comb begin
    csr_word = '0;
    csr_word[INT_EN_BIT] = int_en_r;
    csr_word[INT_POL_BIT] = int_pol_r;
    csr_word[INT_ACT_BIT] = int_act_r;
    csr_word[BUS_INT_EN_BIT] = bus_int_en_r;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else if (data_rd) begin
      rdata_r <= {24'h00_0000, host_q};
    end else if (csr_rd) begin
      rdata_r <= csr_word;
    end else if (unused_acc) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
    end
  end

  assign bus.rdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////
  // processor reset and boot mode

  logic [5:0] rst_cnt_r;
  logic mcu_rst_r;
  logic boot_mode_r;

  // a one-cycle strobe is too short for the processor; stretch it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt_r <= '0;
    end else if (rst_acc) begin
      rst_cnt_r <= PROC_RST_CYC;
    end else if (rst_cnt_r != 6'h0) begin
      rst_cnt_r <= rst_cnt_r - 6'h1;
    end
  end

  // processor also held while the board itself is in reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mcu_rst_r <= 1'b1;
    end else begin
      mcu_rst_r <= (rst_cnt_r != 6'h0);
    end
  end

  // only sampled by firmware at its own start-up
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      boot_mode_r <= MODE_RST;
    end else if (mode_wr) begin
      boot_mode_r <= bus.wdata[MODE_BIT];
    end
  end

  assign mcu_rst = mcu_rst_r;
  assign boot_mode = boot_mode_r;

endmodule : hsp_dev_end

// File: src/hsp_host_end.sv
// host end: turns software commands into byte and word bus cycles
module hsp_host_end
  import hsp_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // async reset, high
  hsp_bus_if.host bus, // board side
  input wire logic [7:0] sw_addr, // register byte address
  input wire logic [31:0] sw_wdata, // write data
  input wire logic sw_wr, // write strobe
  input wire logic sw_rd, // read strobe
  output logic [31:0] sw_rdata, // read data, next cycle
  output logic irq // level interrupt
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ALO = 6'b000010,
    S_AHI = 6'b000100,
    S_DAT = 6'b001000,
    S_ONE = 6'b010000,
    S_CAP = 6'b100000
  } hsp_state_t;

  hsp_state_t state_r, state_nxt;
  logic [9:0] ram_addr_r, cur_r;
  logic [31:0] wdata_r, result_r, rdata_r, bwd_nxt, bwd_r;
  logic [2:0] op_r;
  logic [1:0] idx_r, mask_r, stick_r;
  logic pol_r, act_prev_r, irq_r, done_nxt, go, act;
  logic bsb_nxt, bsd_nxt, bwr_nxt, brd_nxt;
  logic bsb_r, bsd_r, bwr_r, brd_r;
  logic [7:0] bad_nxt, bad_r;

  assign go = sw_wr && (sw_addr == HREG_CMD) && (state_r == S_IDLE);
  assign act = (bus.irq_line == pol_r);

  //////////////////////////////////////////////////////////////////////////
  // sequencer; strobes are registered from the next-state decode
  always_comb begin
    state_nxt = state_r;
    done_nxt = 1'b0;
    {bsb_nxt, bsd_nxt, bwr_nxt, brd_nxt} = 4'h0;
    bad_nxt = 8'h00;
    bwd_nxt = '0;
    unique case (state_r)
      S_IDLE: begin
        if (go && (sw_wdata[2:0] == CMD_WR_BYTE
                   || sw_wdata[2:0] == CMD_RD_WORD)) begin
          state_nxt = S_ALO;
          {bsd_nxt, bwr_nxt} = 2'b11;
          bwd_nxt[7:0] = ram_addr_r[7:0];
        end else if (go && sw_wdata[2:0] >= CMD_PROC_RST
                     && sw_wdata[2:0] <= CMD_BR_RD) begin
          state_nxt = S_ONE;
          bsd_nxt = sw_wdata[2:0] <= CMD_SET_MODE;
          bsb_nxt = sw_wdata[2:0] >= CMD_BR_WR;
          bwr_nxt = sw_wdata[2:0] != CMD_BR_RD;
          brd_nxt = sw_wdata[2:0] == CMD_BR_RD;
          bwd_nxt = wdata_r;
          // mode change is a single write; it does not reset the processor
          unique case (sw_wdata[2:0])
            CMD_PROC_RST: bad_nxt = OFF_PROC_RST;
            CMD_SET_MODE: bad_nxt = OFF_BOOT_MODE;
            default: bad_nxt = OFF_INT_CSR;
          endcase
        end
      end
      S_ALO: begin
        state_nxt = S_AHI;
        {bsd_nxt, bwr_nxt} = 2'b11;
        bad_nxt = OFF_ADDR_HI;
        bwd_nxt[1:0] = cur_r[9:8];
      end
      S_AHI: begin
        // data byte: written for CMD_WR_BYTE, read for CMD_RD_WORD
        state_nxt = S_DAT;
        bsd_nxt = 1'b1;
        bad_nxt = OFF_DATA;
        bwr_nxt = (op_r == CMD_WR_BYTE);
        brd_nxt = (op_r == CMD_RD_WORD);
        bwd_nxt[7:0] = wdata_r[7:0];
      end
      S_DAT: begin
        state_nxt = (op_r == CMD_RD_WORD) ? S_CAP : S_IDLE;
        done_nxt = (op_r != CMD_RD_WORD);
      end
      S_ONE: begin
        state_nxt = (op_r == CMD_BR_RD) ? S_CAP : S_IDLE;
        done_nxt = (op_r != CMD_BR_RD);
      end
      S_CAP: begin
        if (op_r == CMD_RD_WORD && idx_r != 2'(RESULT_BYTES - 1)) begin
          state_nxt = S_ALO;
          {bsd_nxt, bwr_nxt} = 2'b11;
          bwd_nxt[7:0] = 8'(cur_r + 10'h001);
        end else begin
          state_nxt = S_IDLE;
          done_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      {bsb_r, bsd_r, bwr_r, brd_r} <= 4'h0;
      bad_r <= 8'h00;
      bwd_r <= '0;
    end else begin
      state_r <= state_nxt;
      {bsb_r, bsd_r, bwr_r, brd_r} <= {bsb_nxt, bsd_nxt, bwr_nxt, brd_nxt};
      bad_r <= bad_nxt;
      bwd_r <= bwd_nxt;
    end
  end

  assign bus.sel_bridge = bsb_r;
  assign bus.sel_data = bsd_r;
  assign bus.wr = bwr_r;
  assign bus.rd = brd_r;
  assign bus.addr = bad_r;
  assign bus.wdata = bwd_r;

  //////////////////////////////////////////////////////////////////////////
  // command, walking address, result word (low address in low byte)
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      op_r <= 3'h0;
      cur_r <= '0;
      idx_r <= 2'h0;
      result_r <= '0;
      pol_r <= INT_POL_RST;
    end else begin
      if (go) begin
        op_r <= sw_wdata[2:0];
        cur_r <= ram_addr_r;
        idx_r <= 2'h0;
        if (sw_wdata[2:0] == CMD_BR_WR) begin
          pol_r <= wdata_r[INT_POL_BIT];
        end
      end
      if (state_r == S_CAP && op_r == CMD_RD_WORD) begin
        result_r[idx_r*8 +: 8] <= bus.rdata[7:0];
        idx_r <= idx_r + 2'h1;
        cur_r <= cur_r + 10'h001;
      end
      if (state_r == S_CAP && op_r == CMD_BR_RD) begin
        result_r <= bus.rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software registers, sticky status cleared by its read
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ram_addr_r <= '0;
      wdata_r <= '0;
      mask_r <= 2'h0;
      stick_r <= 2'h0;
      rdata_r <= '0;
      act_prev_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      act_prev_r <= act;
      if (sw_wr && sw_addr == HREG_ADDR) ram_addr_r <= sw_wdata[9:0];
      if (sw_wr && sw_addr == HREG_WDATA) wdata_r <= sw_wdata;
      if (sw_wr && sw_addr == HREG_MASK) mask_r <= sw_wdata[1:0];
      // set wins over the read clear
      stick_r <= ((sw_rd && sw_addr == HREG_STAT) ? 2'h0 : stick_r)
        | {act && !act_prev_r, done_nxt};
      irq_r <= |(stick_r & mask_r);
      rdata_r <= '0;
      if (sw_rd) begin
        unique case (sw_addr)
          HREG_ADDR: rdata_r <= {22'h00_0000, ram_addr_r};
          HREG_WDATA: rdata_r <= wdata_r;
          HREG_RDATA: rdata_r <= result_r;
          HREG_STAT: rdata_r <= {29'h0000_0000, state_r != S_IDLE, stick_r};
          HREG_MASK: rdata_r <= {30'h0000_0000, mask_r};
          default: rdata_r <= '0;
        endcase
      end
    end
  end

  assign sw_rdata = rdata_r;
  assign irq = irq_r;
endmodule : hsp_host_end

// File: testbench/hsp_properties.sv
// bus checker standing beside the interface that joins the two ends
module hsp_properties
  import hsp_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // async reset, high
  input wire logic sel_bridge, // bridge region select
  input wire logic sel_data, // data path region select
  input wire logic [BUS_AW-1:0] addr, // byte offset
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [BUS_DW-1:0] wdata, // write data
  input wire logic [BUS_DW-1:0] rdata, // read data
  input wire logic irq_line // board interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic inte_r;
  logic pol_r;
  logic pcien_r;
  logic [9:0] ptr_r;
  logic irq_en;
  logic ptr_lo;
  logic ptr_hi;
  logic dat_acc;
  logic dat_rd;
  assign irq_en = inte_r && pcien_r;
  assign ptr_lo = sel_data && wr && addr == OFF_ADDR_LO;
  assign ptr_hi = sel_data && wr && addr == OFF_ADDR_HI;
  assign dat_acc = sel_data && (wr || rd) && addr == OFF_DATA;
  assign dat_rd = sel_data && rd && addr == OFF_DATA;
  //////////////////////////////////////////////////////////////////////////
  // shadow of the control word, so read-back can be judged
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      inte_r <= INT_EN_RST;
      pol_r <= INT_POL_RST;
      pcien_r <= BUS_INT_EN_RST;
    end else if (sel_bridge && wr && addr == OFF_INT_CSR) begin
      inte_r <= wdata[INT_EN_BIT];
      pol_r <= wdata[INT_POL_BIT];
      pcien_r <= wdata[BUS_INT_EN_BIT];
    end
  end
  // shadow of the ram pointer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_r <= PTR_RST;
    end else if (ptr_lo) begin
      ptr_r <= {ptr_r[9:8], wdata[7:0]};
    end else if (ptr_hi) begin
      ptr_r <= {wdata[1:0], ptr_r[7:0]};
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_RDATA_ONLY_AFTER_RD: assert property (
    (rdata != '0) |-> $past(rd)) else $error("read data without a read");
  AST_STROBES_APART: assert property (
    !(wr && rd)) else $error("read and write strobes together");
  AST_ONE_REGION: assert property (
    (wr || rd) |-> (sel_bridge != sel_data)) else $error("region select");
  AST_BRIDGE_OFFSET: assert property (
    (sel_bridge && (wr || rd)) |-> addr == OFF_INT_CSR)
    else $error("bridge access off the control word");
  AST_DATA_BYTE_WIDE: assert property (
    dat_rd |=> rdata[31:8] == '0) else $error("data byte read too wide");
  AST_CSR_FIELDS: assert property (
    (sel_bridge && rd) |=> rdata[31:7] == '0 && rdata[5:3] == '0 &&
    rdata[6] == pcien_r && rdata[1:0] == {pol_r, inte_r})
    else $error("control word read back wrong");
  AST_MBOX_READ_CLEARS: assert property (
    (dat_rd && ptr_r == MBOX_HOST) |-> ##2 irq_line == !pol_r)
    else $error("mailbox read left interrupt active");
  AST_IRQ_NEEDS_ENABLE: assert property (
    (irq_line == pol_r) |-> $past(irq_en))
    else $error("interrupt active while disabled");
  AST_PTR_PAIRED: assert property (
    ptr_hi |-> $past(ptr_lo)) else $error("high pointer without low");
  AST_DATA_AFTER_PTR: assert property (
    dat_acc |-> $past(ptr_hi)) else $error("data access before pointer");
  cover property (sel_bridge && rd);
  cover property (dat_rd && ptr_r == MBOX_HOST);
  cover property (sel_data && wr && addr == OFF_PROC_RST);
endmodule : hsp_properties

// File: testbench/hsp_tb_top.sv
// testbench joining controller end and board end over the host bus
module hsp_tb_top import hsp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sw_addr = '0;
  logic [31:0] sw_wdata = '0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic irq;
  logic [9:0] mcu_addr = '0;
  logic [7:0] mcu_wdata = '0;
  logic mcu_we = 1'b0;
  logic mcu_re = 1'b0;
  logic [7:0] mcu_rdata;
  logic mcu_rst;
  logic boot_mode;
  logic mcu_mbox_flag;
  int bad_count = 0;
  int num_checks = 0;
  int rst_cyc = 0;
  logic [31:0] d;
  logic [9:0] row_a [3] = '{10'h000, 10'h2a5, 10'h3f8};
  logic [31:0] row_w [3] = '{32'hdead_beef, 32'h0000_0001, 32'hff00_a55a};
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (mcu_rst && !sys_rst) rst_cyc++;
  hsp_bus_if bus();
  hsp_dev_end i_hsp_dev_end (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus(bus), .mcu_addr(mcu_addr), .mcu_wdata(mcu_wdata),
    .mcu_we(mcu_we), .mcu_re(mcu_re), .mcu_rdata(mcu_rdata),
    .mcu_rst(mcu_rst), .boot_mode(boot_mode),
    .mcu_mbox_flag(mcu_mbox_flag));
  hsp_host_end i_hsp_host_end (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus(bus), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
  hsp_properties i_hsp_properties (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sel_bridge(bus.sel_bridge), .sel_data(bus.sel_data), .addr(bus.addr),
    .wr(bus.wr), .rd(bus.rd), .wdata(bus.wdata), .rdata(bus.rdata),
    .irq_line(bus.irq_line));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic sw_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask : sw_write
  // read data stands only in the cycle after the strobe
  task automatic sw_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask : sw_read
  // poll done; the status read also clears the sticky bits
  task automatic run_cmd(input logic [2:0] c, input logic [9:0] a,
                         input logic [31:0] v);
    logic [31:0] s;
    s = '0;
    sw_write(HREG_ADDR, {22'h0, a});
    sw_write(HREG_WDATA, v);
    sw_write(HREG_CMD, {29'h0, c});
    for (int k = 0; k < 40 && !s[ST_DONE]; k++) sw_read(HREG_STAT, s);
    chk(32'(s[ST_DONE]), 32'h1);
  endtask : run_cmd
  task automatic mcu_poke(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    mcu_addr <= a;
    mcu_wdata <= v;
    mcu_we <= 1'b1;
    @(posedge clk_sys);
    mcu_we <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : mcu_poke
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    // released on the edge; outputs keep reset values until the next one
    sys_rst <= 1'b0;
    #1 chk(32'(mcu_rst), 32'h1);
    chk(32'(boot_mode), 32'h0);
    chk(32'(bus.irq_line), 32'h1);
    run_cmd(CMD_BR_RD, 10'h000, 32'h0);
    sw_read(HREG_RDATA, d);
    chk(d, 32'h0000_0001);
    sw_read(8'h1c, d);
    chk(d, 32'h0);
    $display("test reset done");
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 4; i++)
        run_cmd(CMD_WR_BYTE, row_a[r] + 10'(i),
                32'(row_w[r][8*i+:8]));
      run_cmd(CMD_RD_WORD, row_a[r], 32'h0);
      sw_read(HREG_RDATA, d);
      chk(d, row_w[r]);
    end
    $display("test rows done");
    run_cmd(CMD_WR_BYTE, MBOX_MCU, 32'h0000_005a);
    chk(32'(mcu_mbox_flag), 32'h1);
    @(posedge clk_sys);
    mcu_addr <= MBOX_MCU;
    mcu_re <= 1'b1;
    @(posedge clk_sys);
    mcu_re <= 1'b0;
    #1 chk(32'(mcu_rdata), 32'h0000_005a);
    chk(32'(mcu_mbox_flag), 32'h0);
    $display("test mailbox done");
    run_cmd(CMD_SET_MODE, 10'h000, 32'h1);
    chk(32'(boot_mode), 32'h1);
    run_cmd(CMD_SET_MODE, 10'h000, 32'h0);
    chk(32'(boot_mode), 32'h0);
    rst_cyc = 0;
    run_cmd(CMD_PROC_RST, 10'h000, 32'h0);
    repeat (60) @(posedge clk_sys);
    chk(32'(rst_cyc), 32'(PROC_RST_CYC));
    $display("test mode and processor reset done");
    // masked first: sticky must still record the event
    sw_write(HREG_MASK, 32'h0);
    run_cmd(CMD_BR_WR, 10'h000, 32'h0000_0041);
    mcu_poke(MBOX_HOST, 8'h77);
    chk(32'(bus.irq_line), 32'h0);
    chk(32'(irq), 32'h0);
    sw_read(HREG_STAT, d);
    chk(32'(d[ST_DEV]), 32'h1);
    run_cmd(CMD_BR_RD, 10'h000, 32'h0);
    sw_read(HREG_RDATA, d);
    chk(d, 32'h0000_0045);
    run_cmd(CMD_RD_WORD, 10'h3fc, 32'h0);
    chk(32'(bus.irq_line), 32'h1);
    sw_read(HREG_RDATA, d);
    chk(32'(d[31:24]), 32'h0000_0077);
    sw_write(HREG_MASK, 32'h0000_0002);
    mcu_poke(MBOX_HOST, 8'h78);
    chk(32'(irq), 32'h1);
    sw_read(HREG_STAT, d);
    repeat (2) @(posedge clk_sys);
    #1 chk(32'(irq), 32'h0);
    $display("test interrupt done");
    tally_and_finish();
  end
  initial begin
    repeat (6000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish();
  end
endmodule : hsp_tb_top
